// file: hw/ep_buf_pkg.sv
// Shared constants for the indexed endpoint buffer configuration registers.
// Assumes a processor-side register strobe on the controller clock.
// Summary of operation
// - Size-limit write reloads packet byte count.
// - Software may write a smaller byte count.
// - USB bus reset zeroes the byte count.
// - Byte count is 16-bit read/write, indexed.
// - IN writes reaching byte count auto-validate.
// - OUT acknowledge loads received byte count.
// - Odd final byte uses lower lane.
// - Fill status per endpoint, not control.
// - Fill code 00 empty, 01/10 one, 11 both.
// - Size limit excludes setup and control endpoints.
// - Low 11 bits set FIFO size.
// - Two-bit transactions field: one to three.
// - Transactions apply only high-speed iso/interrupt.
// - Count equal to size limit validates.
package ep_buf_pkg;
	localparam logic [7:0] OFS_SIZE_LIMIT  = 8'h04;
	localparam logic [7:0] OFS_BYTE_COUNT  = 8'h1c;
	localparam logic [7:0] OFS_FILL_STATUS = 8'h1e;

	localparam int FIFO_SIZE_W   = 11;
	localparam int TXN_LSB       = 11;
	localparam int TXN_W         = 2;
	localparam int LIMIT_W       = 13;
	localparam int COUNT_W       = 16;
	localparam int FILL_W        = 2;

	localparam logic [LIMIT_W-1:0] LIMIT_RESET = 13'h0000;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [FILL_W-1:0]  FILL_EMPTY  = 2'h0;
	localparam logic [FILL_W-1:0]  FILL_ONE    = 2'h1;
	localparam logic [FILL_W-1:0]  FILL_BOTH   = 2'h3;

	localparam logic [1:0] TXN_RESERVED = 2'h3;
	localparam logic [1:0] TYPE_ISO     = 2'h1;
	localparam logic [1:0] TYPE_INT     = 2'h3;

	localparam int CLK_PERIOD_NS       = 25;
	localparam int STATUS_WAIT_NS      = 200;
	localparam int STATUS_WAIT_CYCLES  = (STATUS_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIFO_TOTAL_BYTES    = 8192;
endpackage : ep_buf_pkg

// file: hw/packet_validator.sv
// Byte accounting for programmed I/O on the indexed endpoint FIFO.
// Assumes clear pulses whenever the index or the packet size changes.
`timescale 1ns/1ps
module packet_validator
(
	input  wire logic        clk,          // Controller clock.
	input  wire logic        nrst,         // Asynchronous reset, active low.
	input  wire logic        clear,        // Restart both byte counters.
	input  wire logic        wrStrobe,     // One data port write.
	input  wire logic        rdStrobe,     // One data port read.
	input  wire logic        wide,         // Access is 16 bits wide.
	input  wire logic [15:0] target,       // Packet byte count of the endpoint.
	input  wire logic [10:0] limit,        // FIFO size of the endpoint.
	output logic             validate_ff,  // Packet auto-validated pulse.
	output logic             lastLow_ff    // Next read holds one byte, lower lane.
);
	logic [15:0] wrCount_ff;
	logic [15:0] rdCount_ff;
	wire  [15:0] step      = wide ? 16'h0002 : 16'h0001;
	wire  [15:0] wrNext    = wrCount_ff + step;
	wire  [15:0] rdNext    = rdCount_ff + step;
	wire  [15:0] limitWide = {5'h00, limit};
	// An odd count finished by a wide write overshoots by one, so compare with >=.
	wire         hitCount  = (target != 16'h0000) && (wrNext >= target);
	wire         hitLimit  = (limitWide != 16'h0000) && (wrNext >= limitWide);
	wire         fire      = wrStrobe && (hitCount || hitLimit);
	wire  [15:0] rdLeft    = target - (rdStrobe ? rdNext : rdCount_ff);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrCount_ff  <= 16'h0000;
			rdCount_ff  <= 16'h0000;
			validate_ff <= 1'b0;
			lastLow_ff  <= 1'b0;
		end
		else
		begin
			validate_ff <= fire && !clear;
			wrCount_ff  <= (clear || fire) ? 16'h0000 : (wrStrobe ? wrNext : wrCount_ff);
			rdCount_ff  <= clear ? 16'h0000 : (rdStrobe ? rdNext : rdCount_ff);
			lastLow_ff  <= !clear && (rdLeft == 16'h0001);
		end
	end

	property p_clear_quiet;
		@(posedge clk) disable iff (!nrst)
		clear |=> !validate_ff && !lastLow_ff;
	endproperty
	a_clear_quiet: assert property (p_clear_quiet) else $error("validate after clear");

	property p_fire;
		@(posedge clk) disable iff (!nrst)
		(wrStrobe && !clear && target != 16'h0000 && wrNext >= target) |=> validate_ff;
	endproperty
	a_fire: assert property (p_fire) else $error("missed auto-validate");
endmodule : packet_validator

// file: hw/endpoint_buffer_config.sv
// Indexed endpoint size limit, packet byte count and fill status registers.
// Assumes the index, endpoint type and engine events come from logic on clk.
`timescale 1ns/1ps
module endpoint_buffer_config
#(
	parameter int NUM_EP        = 16,  // Entries selectable by the index.
	parameter int EP_IDX_W      = 4,   // Width of the endpoint index.
	parameter int FIRST_DATA_EP = 2    // Indices below this are control endpoints.
)
(
	input  wire logic                clk,          // Controller clock, 40 MHz.
	input  wire logic                nrst,         // Asynchronous reset, active low.
	input  wire logic                busReset,     // USB bus reset seen, level.
	input  wire logic [7:0]          regAddr,      // Register byte address.
	input  wire logic                regWrEn,      // Register write strobe.
	input  wire logic                regRdEn,      // Register read strobe.
	input  wire logic [15:0]         regWrData,    // Register write data.
	output logic      [15:0]         regRdData,    // Register read data.
	input  wire logic [EP_IDX_W-1:0] epIndex,      // Selected endpoint.
	input  wire logic                highSpeed,    // Link runs at high speed.
	input  wire logic [1:0]          epType,       // Type of the selected endpoint.
	input  wire logic                pioWrite,     // Data port write, IN endpoint.
	input  wire logic                pioRead,      // Data port read, OUT endpoint.
	input  wire logic                pioWide,      // Data port access is 16 bits.
	input  wire logic                outAckValid,  // OUT data packet acknowledged.
	input  wire logic [EP_IDX_W-1:0] outAckEp,     // Endpoint of the acknowledge.
	input  wire logic [15:0]         outAckBytes,  // Bytes received in the packet.
	input  wire logic                fillInc,      // One buffer became full.
	input  wire logic                fillDec,      // One buffer became empty.
	input  wire logic [EP_IDX_W-1:0] fillEp,       // Endpoint of the fill event.
	output logic                     autoValidate, // IN packet validated pulse.
	output logic      [1:0]          txnPerUframe, // Packets per microframe, 1..3.
	output logic                     lastByteLow   // Next wide read carries one byte.
);
	logic [ep_buf_pkg::LIMIT_W-1:0] limitArr [NUM_EP];
	logic [ep_buf_pkg::COUNT_W-1:0] countArr [NUM_EP];
	logic [ep_buf_pkg::FILL_W-1:0]  fillArr  [NUM_EP];
	logic [15:0]                    rdData_ff;
	logic [1:0]                     txn_ff;
	logic [EP_IDX_W-1:0]            idxPrev_ff;

	// Address decode and the selected entry.
	wire isCtrl   = epIndex < EP_IDX_W'(FIRST_DATA_EP);
	wire selLimit = (regAddr == ep_buf_pkg::OFS_SIZE_LIMIT);
	wire selCount = (regAddr == ep_buf_pkg::OFS_BYTE_COUNT);
	wire selFill  = (regAddr == ep_buf_pkg::OFS_FILL_STATUS);
	wire limitWr  = regWrEn && selLimit && !isCtrl;
	wire countWr  = regWrEn && selCount;
	wire [ep_buf_pkg::LIMIT_W-1:0] curLimit = limitArr[epIndex];
	wire [ep_buf_pkg::COUNT_W-1:0] curCount = countArr[epIndex];
	wire [ep_buf_pkg::FILL_W-1:0]  curFill  = fillArr[epIndex];
	wire [10:0] wrFifoSize = regWrData[ep_buf_pkg::FIFO_SIZE_W-1:0];
	wire [1:0]  curTxn     = curLimit[ep_buf_pkg::TXN_LSB +: ep_buf_pkg::TXN_W];
	wire        outAckCur  = outAckValid && (outAckEp == epIndex);

	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++)
		begin : g_entry
			wire hit     = (epIndex == EP_IDX_W'(g));
			wire ackHit  = outAckValid && (outAckEp == EP_IDX_W'(g));
			wire fillHit = fillEp == EP_IDX_W'(g);
			wire up      = fillHit && fillInc && !fillDec;
			wire down    = fillHit && fillDec && !fillInc;
			wire [ep_buf_pkg::FILL_W-1:0] fillUp =
				(fillArr[g] == ep_buf_pkg::FILL_EMPTY) ? ep_buf_pkg::FILL_ONE
				                                       : ep_buf_pkg::FILL_BOTH;
			wire [ep_buf_pkg::FILL_W-1:0] fillDown =
				(fillArr[g] == ep_buf_pkg::FILL_BOTH) ? ep_buf_pkg::FILL_ONE
				                                      : ep_buf_pkg::FILL_EMPTY;

			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
					limitArr[g] <= ep_buf_pkg::LIMIT_RESET;
				else if (busReset)
					limitArr[g] <= ep_buf_pkg::LIMIT_RESET;
				else if (limitWr && hit)
					limitArr[g] <= regWrData[ep_buf_pkg::LIMIT_W-1:0];
			end

			// The acknowledge from the link wins over a register write in the same cycle.
			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
					countArr[g] <= ep_buf_pkg::COUNT_RESET;
				else if (busReset)
					countArr[g] <= ep_buf_pkg::COUNT_RESET;
				else if (ackHit)
					countArr[g] <= outAckBytes;
				else if (limitWr && hit)
					countArr[g] <= {5'h00, wrFifoSize};
				else if (countWr && hit)
					countArr[g] <= regWrData;
			end

			always_ff @(posedge clk or negedge nrst)
			begin
				if (!nrst)
					fillArr[g] <= ep_buf_pkg::FILL_EMPTY;
				else if (busReset)
					fillArr[g] <= ep_buf_pkg::FILL_EMPTY;
				else if (up)
					fillArr[g] <= fillUp;
				else if (down)
					fillArr[g] <= fillDown;
			end
		end
	endgenerate

	// Read selection; control endpoints have no double buffer to report.
	wire [15:0] fillWord  = isCtrl ? 16'h0000 : {14'h0000, curFill};
	wire [15:0] limitWord = {3'h0, curLimit};
	wire [15:0] rdMux     = selLimit ? limitWord :
	                        selCount ? curCount  :
	                        selFill  ? fillWord  : 16'h0000;

	// Transactions only matter for high-speed periodic endpoints; reserved falls back to one.
	wire        periodic = (epType == ep_buf_pkg::TYPE_ISO) || (epType == ep_buf_pkg::TYPE_INT);
	wire        useTxn   = highSpeed && periodic && (curTxn != ep_buf_pkg::TXN_RESERVED);
	wire [1:0]  nxt_txn  = useTxn ? (curTxn + 2'h1) : 2'h1;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdData_ff  <= 16'h0000;
			txn_ff     <= 2'h1;
			idxPrev_ff <= '0;
		end
		else
		begin
			rdData_ff  <= regRdEn ? rdMux : rdData_ff;
			txn_ff     <= nxt_txn;
			idxPrev_ff <= epIndex;
		end
	end

	// Restarting the counters on any change keeps a stale partial count off a new packet.
	wire vClear = busReset || (idxPrev_ff != epIndex) || limitWr || countWr || outAckCur;

	packet_validator u_validator
	(
		.clk         (clk),
		.nrst        (nrst),
		.clear       (vClear),
		.wrStrobe    (pioWrite),
		.rdStrobe    (pioRead),
		.wide        (pioWide),
		.target      (curCount),
		.limit       (curLimit[ep_buf_pkg::FIFO_SIZE_W-1:0]),
		.validate_ff (autoValidate),
		.lastLow_ff  (lastByteLow)
	);

	assign regRdData    = rdData_ff;
	assign txnPerUframe = txn_ff;

	property p_reload;
		@(posedge clk) disable iff (!nrst)
		(limitWr && !outAckCur && !busReset) ##1 $stable(epIndex)
		|-> curCount == {5'h00, $past(wrFifoSize)};
	endproperty
	a_reload: assert property (p_reload) else $error("count not reloaded");

	property p_sw_count;
		@(posedge clk) disable iff (!nrst)
		(countWr && !outAckCur && !busReset) ##1 $stable(epIndex)
		|-> curCount == $past(regWrData);
	endproperty
	a_sw_count: assert property (p_sw_count) else $error("count write lost");

	property p_bus_reset;
		@(posedge clk) disable iff (!nrst)
		busReset |=> (curCount == 16'h0000) && (curFill == ep_buf_pkg::FILL_EMPTY);
	endproperty
	a_bus_reset: assert property (p_bus_reset) else $error("bus reset not cleared");

	property p_out_ack;
		@(posedge clk) disable iff (!nrst)
		(outAckCur && !busReset) ##1 $stable(epIndex) |-> curCount == $past(outAckBytes);
	endproperty
	a_out_ack: assert property (p_out_ack) else $error("received count not loaded");

	property p_ctrl_fill;
		@(posedge clk) disable iff (!nrst)
		(regRdEn && selFill && isCtrl) |=> regRdData == 16'h0000;
	endproperty
	a_ctrl_fill: assert property (p_ctrl_fill) else $error("control fill not zero");

	property p_fill_code;
		@(posedge clk) disable iff (!nrst)
		(regRdEn && selFill) |=> (regRdData[15:2] == 14'h0000) && (regRdData[1:0] != 2'h2);
	endproperty
	a_fill_code: assert property (p_fill_code) else $error("bad fill code");

	property p_ctrl_limit;
		@(posedge clk) disable iff (!nrst)
		(regWrEn && selLimit && isCtrl && !busReset) ##1 $stable(epIndex) |-> $stable(curLimit);
	endproperty
	a_ctrl_limit: assert property (p_ctrl_limit) else $error("control size written");

	property p_limit_rsvd;
		@(posedge clk) disable iff (!nrst)
		(regRdEn && selLimit) |=> regRdData[15:13] == 3'h0;
	endproperty
	a_limit_rsvd: assert property (p_limit_rsvd) else $error("reserved bits set");

	property p_txn;
		@(posedge clk) disable iff (!nrst)
		(!highSpeed || !periodic) |=> txnPerUframe == 2'h1;
	endproperty
	a_txn: assert property (p_txn) else $error("transactions applied wrongly");

	property p_txn_hs;
		@(posedge clk) disable iff (!nrst)
		(highSpeed && periodic && curTxn == 2'h2) |=> txnPerUframe == 2'h3;
	endproperty
	a_txn_hs: assert property (p_txn_hs) else $error("three packets not set");
endmodule : endpoint_buffer_config

// file: test/usb_host_model.sv
// Far-side stand-in for the USB host: acknowledges OUT packets and moves buffers.
// Assumes the bench calls its tasks from one process synchronised to clk.
`timescale 1ns/1ps
module usb_host_model
(
	input  wire logic        clk,      // Controller clock.
	output logic             ackValid, // OUT packet acknowledged.
	output logic      [3:0]  ackEp,    // Endpoint acknowledged.
	output logic      [15:0] ackBytes, // Bytes received in the packet.
	output logic             inc,      // One buffer filled.
	output logic             dec,      // One buffer emptied.
	output logic      [3:0]  evEp      // Endpoint of the buffer event.
);
	initial
	begin
		ackValid = 1'b0;
		ackEp = 4'hf;
		ackBytes = 16'h5a5a;
		inc = 1'b0;
		dec = 1'b0;
		evEp = 4'hf;
	end

	task ack(input logic [3:0] ep, input logic [15:0] n);
		@(posedge clk);
		ackValid <= 1'b1;
		ackEp <= ep;
		ackBytes <= n;
		@(posedge clk);
		ackValid <= 1'b0;
		// Idle fields are inverted so that a design latching late sees garbage.
		ackEp <= ~ep;
		ackBytes <= ~n;
	endtask : ack

	task fill(input logic [3:0] ep, input logic up);
		@(posedge clk);
		inc <= up;
		dec <= ~up;
		evEp <= ep;
		@(posedge clk);
		inc <= 1'b0;
		dec <= 1'b0;
		evEp <= ~ep;
	endtask : fill
endmodule : usb_host_model

// file: test/endpoint_buffer_config_tb.sv
// Self-checking bench for the indexed endpoint buffer registers.
// Assumes the design and usb_host_model are compiled before this file.
`timescale 1ns/1ps
module endpoint_buffer_config_tb;
	typedef struct {logic [3:0] ep; logic [15:0] wd; logic [1:0] typ; logic hs;
		logic [15:0] lim; logic [15:0] cnt; logic [1:0] txn;} row_t;
	logic clk = 1'b0, nrst = 1'b0, busReset = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWrData = 16'h0000, regRdData, v;
	logic [3:0] epIndex = 4'h2, outAckEp, fillEp;
	logic highSpeed = 1'b0, pioWrite = 1'b0, pioRead = 1'b0, pioWide = 1'b0;
	logic [1:0] epType = 2'h2, txnPerUframe;
	logic outAckValid, fillInc, fillDec, autoValidate, lastByteLow;
	logic [15:0] outAckBytes;
	int errors = 0, checks_done = 0, pulses;
	row_t rows[7] = '{ // Sizes stay far inside the shared FIFO.
		'{4'h2, 16'hf840, 2'h1, 1'b1, 16'h1840, 16'h0040, 2'h1},
		'{4'h2, 16'h0200, 2'h1, 1'b1, 16'h0200, 16'h0200, 2'h1},
		'{4'h3, 16'h0a00, 2'h3, 1'b1, 16'h0a00, 16'h0200, 2'h2},
		'{4'h3, 16'h1400, 2'h1, 1'b1, 16'h1400, 16'h0400, 2'h3},
		'{4'h3, 16'h1400, 2'h2, 1'b1, 16'h1400, 16'h0400, 2'h1},
		'{4'h4, 16'h1400, 2'h1, 1'b0, 16'h1400, 16'h0400, 2'h1},
		'{4'h0, 16'h0040, 2'h2, 1'b1, 16'h0000, 16'h0000, 2'h1}};

	always #12.5 clk = ~clk;

	endpoint_buffer_config u_endpoint_buffer_config (.clk(clk), .nrst(nrst),
		.busReset(busReset), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regWrData(regWrData), .regRdData(regRdData), .epIndex(epIndex),
		.highSpeed(highSpeed), .epType(epType), .pioWrite(pioWrite), .pioRead(pioRead),
		.pioWide(pioWide), .outAckValid(outAckValid), .outAckEp(outAckEp),
		.outAckBytes(outAckBytes), .fillInc(fillInc), .fillDec(fillDec), .fillEp(fillEp),
		.autoValidate(autoValidate), .txnPerUframe(txnPerUframe), .lastByteLow(lastByteLow));
	usb_host_model u_usb_host_model (.clk(clk), .ackValid(outAckValid), .ackEp(outAckEp),
		.ackBytes(outAckBytes), .inc(fillInc), .dec(fillDec), .evEp(fillEp));

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// A request is held for one edge; read data is taken one edge later, while it stands.
	task bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrEn <= wr;
		regRdEn <= ~wr;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrEn <= 1'b0;
		regRdEn <= 1'b0;
		@(posedge clk);
		v = regRdData;
	endtask : bus

	task pio(input logic wr, input logic wide);
		@(posedge clk);
		pioWrite <= wr;
		pioRead <= ~wr;
		pioWide <= wide;
		@(posedge clk);
		pioWrite <= 1'b0;
		pioRead <= 1'b0;
	endtask : pio

	task stop_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	always @(posedge clk)
		if (autoValidate === 1'b1)
			pulses++;

	initial
	begin
		repeat (5000) @(posedge clk);
		errors++;
		stop_test;
	end

	initial
	begin
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		bus(1'b0, 8'h1c, 16'h0000);
		chk(v, 16'h0000);
		for (int i = 0; i < 7; i++)
		begin
			epIndex <= rows[i].ep;
			epType <= rows[i].typ;
			highSpeed <= rows[i].hs;
			bus(1'b1, 8'h04, rows[i].wd);
			bus(1'b0, 8'h04, 16'h0000);
			chk(v, rows[i].lim);
			bus(1'b0, 8'h1c, 16'h0000);
			chk(v, rows[i].cnt);
			chk({14'h0000, txnPerUframe}, {14'h0000, rows[i].txn});
		end
		epIndex <= 4'h2;
		bus(1'b1, 8'h1c, 16'h0003);
		bus(1'b0, 8'h1c, 16'h0000);
		chk(v, 16'h0003);
		pulses = 0;
		pio(1'b1, 1'b1);
		pio(1'b1, 1'b0);
		repeat (3) @(posedge clk);
		chk(16'(pulses), 16'h0001);
		bus(1'b1, 8'h1c, 16'h0003);
		pio(1'b0, 1'b1);
		repeat (2) @(posedge clk);
		chk({15'h0000, lastByteLow}, 16'h0001);
		// A byte count above the size limit leaves the size limit to end the packet.
		bus(1'b1, 8'h04, 16'h0002);
		bus(1'b1, 8'h1c, 16'h0010);
		pulses = 0;
		pio(1'b1, 1'b1);
		repeat (3) @(posedge clk);
		chk(16'(pulses), 16'h0001);
		u_usb_host_model.ack(4'h2, 16'h0155);
		repeat (8) @(posedge clk);
		bus(1'b0, 8'h1c, 16'h0000);
		chk(v, 16'h0155);
		epIndex <= 4'h3;
		bus(1'b1, 8'h1e, 16'h00ff);
		bus(1'b0, 8'h1e, 16'h0000);
		chk(v, 16'h0000);
		u_usb_host_model.fill(4'h3, 1'b1);
		repeat (8) @(posedge clk);
		bus(1'b0, 8'h1e, 16'h0000);
		chk(v, 16'h0001);
		u_usb_host_model.fill(4'h3, 1'b1);
		bus(1'b0, 8'h1e, 16'h0000);
		chk(v, 16'h0003);
		u_usb_host_model.fill(4'h3, 1'b0);
		bus(1'b0, 8'h1e, 16'h0000);
		chk(v, 16'h0001);
		bus(1'b0, 8'h10, 16'h0000);
		chk(v, 16'h0000);
		epIndex <= 4'h0;
		u_usb_host_model.fill(4'h0, 1'b1);
		bus(1'b0, 8'h1e, 16'h0000);
		chk(v, 16'h0000);
		@(posedge clk);
		busReset <= 1'b1;
		@(posedge clk);
		busReset <= 1'b0;
		epIndex <= 4'h2;
		bus(1'b0, 8'h1c, 16'h0000);
		chk(v, 16'h0000);
		epIndex <= 4'h3;
		bus(1'b0, 8'h1e, 16'h0000);
		chk(v, 16'h0000);
		// With count and size both cleared nothing validates, so firmware must do it.
		epIndex <= 4'h2;
		pulses = 0;
		pio(1'b1, 1'b1);
		pio(1'b1, 1'b1);
		repeat (3) @(posedge clk);
		chk(16'(pulses), 16'h0000);
		stop_test;
	end
endmodule : endpoint_buffer_config_tb
